// ### pkg/ldo_ctl_pkg.sv
package ldo_ctl_pkg;
  localparam int CLK_MHZ = 20;
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_BYPASS = 2'h1;
  localparam logic [1:0] MODE_SWITCH = 2'h2;
  localparam logic [1:0] MODE_EXTMON = 2'h3;
  localparam int BLANK_US_0 = 250;
  localparam int BLANK_US_1 = 500;
  localparam int BLANK_US_2 = 1000;
  localparam int BLANK_US_3 = 2500;
  localparam int MASK_US_0 = 500;
  localparam int MASK_US_1 = 1000;
  localparam int MASK_US_2 = 2000;
  localparam int MASK_US_3 = 5000;
  localparam int TMR_W = 17;
  localparam int DISCH_US = 600;
  localparam int DISCH_CYC = DISCH_US * CLK_MHZ;
  localparam logic [4:0] VCODE_RST = 5'h00;
  localparam logic [7:0] SLOT_RST = 8'h00;
  // register map of the software port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_VOLT = 4'h1;
  localparam logic [3:0] ADDR_SLOT = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam int CTRL_RUN_EN = 0;
  localparam int CTRL_STBY_EN = 1;
  localparam int IRQ_W = 4;
  localparam int EV_OV = 0;
  localparam int EV_UV = 1;
  localparam int EV_BLANK_DONE = 2;
  localparam int EV_MASK_DONE = 3;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT_SLOT = 3'b001,
    ST_ON = 3'b010,
    ST_DISCH = 3'b011,
    ST_TRI = 3'b100
  } out_state_e;
endpackage

// ### pkg/ldo_tmr_if.sv
interface ldo_tmr_if;
  logic start;
  logic [1:0] sel;
  logic early_stop;
  logic busy;
  logic done;
  modport ctl (output start, output sel, output early_stop, input busy, input done);
  modport tmr (input start, input sel, input early_stop, output busy, output done);
endinterface

// ### src/ldo_blank_timer.sv
module ldo_blank_timer #(
  parameter int US_0 = 250,
  parameter int US_1 = 500,
  parameter int US_2 = 1000,
  parameter int US_3 = 2500
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  ldo_tmr_if.tmr t
);
  import ldo_ctl_pkg::*;
  // cycle counts derived from the microsecond figures
  localparam logic [TMR_W-1:0] CYC_0 = TMR_W'(US_0 * CLK_MHZ);
  localparam logic [TMR_W-1:0] CYC_1 = TMR_W'(US_1 * CLK_MHZ);
  localparam logic [TMR_W-1:0] CYC_2 = TMR_W'(US_2 * CLK_MHZ);
  localparam logic [TMR_W-1:0] CYC_3 = TMR_W'(US_3 * CLK_MHZ);
  logic [TMR_W-1:0] cnt_r;
  wire [TMR_W-1:0] load_val = (t.sel == 2'h0) ? CYC_0 : (t.sel == 2'h1) ? CYC_1 :
                              (t.sel == 2'h2) ? CYC_2 : CYC_3;
  assign t.busy = (cnt_r != '0);
  assign t.done = (cnt_r == TMR_W'(1)) && !t.start && !t.early_stop;
  // down-counter; early stop abandons the remaining time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (t.start) begin
      cnt_r <= load_val;
    end else if (t.early_stop) begin
      cnt_r <= '0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - TMR_W'(1);
    end
  end
endmodule

// ### src/ldo_mode_monitor_control.sv
// Behaviour
// [RULE_01] two-bit field picks one of four modes
// [RULE_02] load switch: plain on/off by enables, slot
// [RULE_03] switch mode level: run code, standby code
// [RULE_04] bypass: only monitor on, through RUN
// [RULE_05] bypass turn-on blanks faults, four durations
// [RULE_06] blanking only on turn-on as monitor
// [RULE_07] supply in regulation ends blanking early
// [RULE_08] setpoint change in RUN masks faults
// [RULE_09] standby output only if enable, at slot
// [RULE_10] monitored standby: discharge when target drops
// [RULE_11] low-power standby: monitor off, tri-state
// [RULE_12] avoid bypass when standby supervision matters
// [RULE_13] external regulator must release high impedance
// [RULE_14] external regulator tolerates pre-biased start
// [RULE_15] run enable defaults from sequence membership
// [RULE_16] standby enable, codes load from defaults
// [RULE_17] timers are down-counters on reference clock
module ldo_mode_monitor_control #(
  parameter int DISCH_CYCLES = ldo_ctl_pkg::DISCH_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [1:0] i_channel_mode_select,
  input wire logic i_low_power_standby_select,
  input wire logic i_in_sequence,
  input wire logic i_standby_enable_default,
  input wire logic [4:0] i_run_code_default,
  input wire logic [4:0] i_stby_code_default,
  input wire logic [1:0] i_monitor_blanking_select,
  input wire logic [1:0] i_monitor_mask_select,
  input wire logic i_load_defaults,
  input wire logic i_state_run,
  input wire logic i_state_standby,
  input wire logic [7:0] i_slot_now,
  input wire logic i_slot_tick,
  input wire logic i_in_regulation,
  input wire logic i_ov_raw,
  input wire logic i_uv_raw,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_regulator_on,
  output logic o_channel_voltage_monitor_en,
  output logic [4:0] o_monitor_level,
  output logic o_discharge_on,
  output logic o_output_tristate,
  output logic o_ov_fault,
  output logic o_uv_fault,
  output logic o_irq
);
  import ldo_ctl_pkg::*;

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic run_output_enable_r;
  logic standby_output_enable_r;
  logic [4:0] run_voltage_code_r;
  logic [4:0] standby_voltage_code_r;
  logic [7:0] sequence_slot_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [7:0] rdata_r;
  out_state_e st_r;
  out_state_e st_nxt;
  logic run_d_r;
  logic stby_d_r;
  logic [$clog2(DISCH_CYCLES+1)-1:0] dis_cnt_r;

  // mode decode
  wire mode_reg = (i_channel_mode_select == MODE_REG); // RULE_01
  wire mode_byp = (i_channel_mode_select == MODE_BYPASS); // RULE_01
  wire mode_sw = (i_channel_mode_select == MODE_SWITCH); // RULE_01
  wire mode_ext = (i_channel_mode_select == MODE_EXTMON); // RULE_01

  // bus decode
  wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
  wire wr_volt = i_wr && (i_addr == ADDR_VOLT);
  wire wr_slot = i_wr && (i_addr == ADDR_SLOT);
  wire wr_mask = i_wr && (i_addr == ADDR_MASK);
  wire rd_irq = i_rd && (i_addr == ADDR_IRQ);

  // setpoint write during RUN changes the expected level
  wire run_code_chg = wr_volt && i_state_run && (i_wdata[4:0] != run_voltage_code_r);

  // defaults load at power-up; software writes afterwards
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      run_output_enable_r <= 1'b0;
      standby_output_enable_r <= 1'b0;
      run_voltage_code_r <= VCODE_RST;
      standby_voltage_code_r <= VCODE_RST;
      sequence_slot_r <= SLOT_RST;
      irq_mask_r <= '0;
    end else if (i_load_defaults) begin
      run_output_enable_r <= i_in_sequence; // RULE_15
      standby_output_enable_r <= i_standby_enable_default; // RULE_16
      run_voltage_code_r <= i_run_code_default; // RULE_16
      standby_voltage_code_r <= i_stby_code_default; // RULE_16
    end else begin
      if (wr_ctrl) begin
        run_output_enable_r <= i_wdata[CTRL_RUN_EN];
        standby_output_enable_r <= i_wdata[CTRL_STBY_EN];
      end
      if (wr_volt) begin
        run_voltage_code_r <= i_wdata[4:0];
      end
      if (wr_slot) begin
        sequence_slot_r <= i_wdata;
      end
      if (wr_mask) begin
        irq_mask_r <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // ************************************************************
  // output sequencing
  // ************************************************************
  wire want_run = i_state_run && run_output_enable_r;
  wire want_stby = i_state_standby && standby_output_enable_r; // RULE_09
  wire want_on = want_run || want_stby; // RULE_02
  wire slot_hit = i_slot_tick && (i_slot_now == sequence_slot_r); // RULE_09
  wire stby_entry = i_state_standby && !stby_d_r;
  wire drop_level = standby_voltage_code_r < run_voltage_code_r;
  wire dis_done = (dis_cnt_r == '0);

  // next state of the output gate
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: begin
        if (want_on) begin
          st_nxt = ST_WAIT_SLOT;
        end
      end
      ST_WAIT_SLOT: begin
        if (!want_on) begin
          st_nxt = ST_OFF;
        end else if (slot_hit || (i_state_run && run_d_r)) begin
          st_nxt = ST_ON; // RULE_09
        end
      end
      ST_ON: begin
        if (stby_entry && i_low_power_standby_select) begin
          st_nxt = ST_TRI; // RULE_11
        end else if (stby_entry && drop_level) begin
          st_nxt = ST_DISCH; // RULE_10
        end else if (!want_on) begin
          st_nxt = ST_OFF;
        end
      end
      ST_DISCH: begin
        if (dis_done) begin
          st_nxt = want_stby ? ST_WAIT_SLOT : ST_OFF;
        end
      end
      ST_TRI: begin
        if (!i_state_standby || want_stby) begin
          st_nxt = want_on ? ST_WAIT_SLOT : ST_OFF;
        end
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  // state, discharge counter and entry detectors
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r <= ST_OFF;
      run_d_r <= 1'b0;
      stby_d_r <= 1'b0;
      dis_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      run_d_r <= i_state_run;
      stby_d_r <= i_state_standby;
      if (st_r != ST_DISCH && st_nxt == ST_DISCH) begin
        dis_cnt_r <= ($clog2(DISCH_CYCLES+1))'(DISCH_CYCLES); // RULE_10
      end else if (!dis_done) begin
        dis_cnt_r <= dis_cnt_r - 1'b1;
      end
    end
  end

  // ************************************************************
  // monitor, blanking and masking
  // ************************************************************
  wire on_now = (st_r == ST_ON);
  wire turn_on = (st_r != ST_ON) && (st_nxt == ST_ON);
  wire lp_stby = i_state_standby && i_low_power_standby_select;
  // bypass keeps the pass device off; only the monitor runs
  assign o_regulator_on = on_now && !mode_byp && !mode_ext; // RULE_04
  assign o_channel_voltage_monitor_en = !lp_stby &&
    (on_now || st_r == ST_DISCH || (mode_byp && i_state_run)); // RULE_04 RULE_11
  assign o_monitor_level = i_state_standby ? standby_voltage_code_r : run_voltage_code_r; // RULE_03
  assign o_discharge_on = (st_r == ST_DISCH); // RULE_10
  assign o_output_tristate = (st_r == ST_TRI) || !o_regulator_on; // RULE_11

  ldo_tmr_if blank_if ();
  ldo_tmr_if mask_if ();
  // blanking only when turning on as monitor of the outside supply
  assign blank_if.start = turn_on && mode_byp && !i_state_standby; // RULE_05 RULE_06
  assign blank_if.sel = i_monitor_blanking_select;
  assign blank_if.early_stop = i_in_regulation; // RULE_07
  assign mask_if.start = run_code_chg; // RULE_08
  assign mask_if.sel = i_monitor_mask_select;
  assign mask_if.early_stop = 1'b0;

  ldo_blank_timer #(.US_0(BLANK_US_0), .US_1(BLANK_US_1), .US_2(BLANK_US_2), .US_3(BLANK_US_3))
    u_blank (.i_clk(I_CLK), .i_rst_n(I_RST_N), .t(blank_if)); // RULE_17
  ldo_blank_timer #(.US_0(MASK_US_0), .US_1(MASK_US_1), .US_2(MASK_US_2), .US_3(MASK_US_3))
    u_mask (.i_clk(I_CLK), .i_rst_n(I_RST_N), .t(mask_if)); // RULE_17

  // a bypass channel still waiting to turn on has not started blanking yet, so faults wait too
  wire byp_pending = mode_byp && want_on && !on_now; // RULE_05
  // faults pass only when monitoring and neither timer holds them
  wire fault_ok = o_channel_voltage_monitor_en && !blank_if.busy && !mask_if.busy && !blank_if.start
                  && !mask_if.start && !o_discharge_on && !byp_pending;
  assign o_ov_fault = fault_ok && i_ov_raw; // RULE_05 RULE_08
  assign o_uv_fault = fault_ok && i_uv_raw; // RULE_05 RULE_08

  // ************************************************************
  // interrupts and read port
  // ************************************************************
  // fault events are levels: a standing fault sets its bit again every cycle
  wire [IRQ_W-1:0] ev = {mask_if.done, blank_if.done, o_uv_fault, o_ov_fault};
  // set wins over the clear-on-read
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | ev;
    end
  end
  // a set mask bit keeps its status bit off the interrupt line
  assign o_irq = |(irq_stat_r & ~irq_mask_r);

  wire [7:0] rd_mux =
    (i_addr == ADDR_CTRL) ? {6'h00, standby_output_enable_r, run_output_enable_r} :
    (i_addr == ADDR_VOLT) ? {3'h0, run_voltage_code_r} :
    (i_addr == ADDR_SLOT) ? sequence_slot_r :
    (i_addr == ADDR_STAT) ? {mode_reg, mode_sw, blank_if.busy, mask_if.busy, 1'b0, st_r} :
    (i_addr == ADDR_IRQ) ? {4'h0, irq_stat_r} :
    (i_addr == ADDR_MASK) ? {4'h0, irq_mask_r} : 8'h00;
  // read data stand only in the cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= i_rd ? rd_mux : 8'h00;
    end
  end
  assign o_rdata = rdata_r;

  // ************************************************************
  // checks
  // ************************************************************
  blank_mask_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_05
    blank_if.busy |-> !o_ov_fault && !o_uv_fault) else $error("fault passed during blanking");
  blank_start_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_06
    $rose(blank_if.busy) |-> on_now && $past(mode_byp) && !$past(i_state_standby))
    else $error("blanking outside bypass turn-on");
  early_end_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_07
    i_in_regulation && !blank_if.start |=> !blank_if.busy) else $error("blanking not ended early");
  mask_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_08
    run_code_chg |=> mask_if.busy [*8]) else $error("masking too short");
  stby_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_09
    i_state_standby && !i_state_run && !standby_output_enable_r && $stable(i_state_standby)
    |=> st_r != ST_ON) else $error("standby output on while disabled");
  lp_tri_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_11
    lp_stby |-> !o_channel_voltage_monitor_en) else $error("monitor on in low-power standby");
  disch_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_10
    on_now && stby_entry && !i_low_power_standby_select && drop_level |=> o_discharge_on)
    else $error("no discharge on lowering entry");
  defaults_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_15
    i_load_defaults |=> run_output_enable_r == $past(i_in_sequence)) else $error("run enable default wrong");
  level_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_03
    i_state_standby |-> o_monitor_level == standby_voltage_code_r) else $error("wrong monitor level");
  // sequencing, masking and interrupt checks
  gate_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_02
    !want_on |=> !on_now)
    else $error("output on with no enable");
  slot_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_09
    st_r == ST_WAIT_SLOT && !i_state_run && !slot_hit |=> !on_now)
    else $error("standby output on before its slot");
  lp_entry_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_11
    on_now && stby_entry && i_low_power_standby_select |=> o_output_tristate && !o_discharge_on)
    else $error("low-power entry not tri-stated");
  disch_end_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_10
    o_discharge_on && dis_done |=> !o_discharge_on)
    else $error("discharge outlasts its count");
  mask_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_08
    mask_if.busy |-> !o_ov_fault && !o_uv_fault)
    else $error("fault passed during masking");
  mask_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_08
    mask_if.done |=> irq_stat_r[EV_MASK_DONE])
    else $error("masking end not flagged");
  byp_mon_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_04
    mode_byp && i_state_run && !i_state_standby |-> o_channel_voltage_monitor_en && !o_regulator_on)
    else $error("bypass drives output or monitor off");
endmodule

// ### dv/ext_reg_model.sv
// ****************************************************************
// external high-power regulator supervised at the channel pin
// ****************************************************************
module ext_reg_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_slow,
  input wire logic i_ov_cmd,
  input wire logic i_uv_cmd,
  output logic o_in_regulation,
  output logic o_ov_raw,
  output logic o_uv_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ramp_r;
  // ramp restarts on each enable; a pre-biased start just reaches regulation
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ramp_r <= 16'h0000;
    end else if (!i_en) begin
      ramp_r <= 16'h0000;
    end else if (ramp_r != 16'hFFFF) begin
      ramp_r <= ramp_r + 16'h0001;
    end
  end
  // slow ramp outlasts the 250 and 500 us blanking times, so those must run full length
  assign o_in_regulation = i_en && (ramp_r >= (i_slow ? 16'h3000 : 16'h0002));
  assign o_ov_raw = i_en & i_ov_cmd;
  assign o_uv_raw = i_en & i_uv_cmd;
endmodule

// ### dv/ldo_mode_monitor_control_test.sv
// ****************************************************************
// channel control bench
// ****************************************************************
module ldo_mode_monitor_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ldo_ctl_pkg::*;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
  localparam int DISCH = 20;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [1:0] mode, blank_sel, mask_sel;
  logic lp, in_seq, stby_def, load_def, st_run, st_stby, slot_tick, wr, rd;
  logic ext_en, ext_slow, ov_cmd, uv_cmd, in_reg, ov_raw, uv_raw;
  logic reg_on, mon_en, disch, tri_st, ov_f, uv_f, irq;
  logic [4:0] run_def, stby_code, mon_lvl;
  logic [7:0] slot_now, wdata, rdata, d;
  logic [3:0] addr;
  int err_total = 0;
  int n_compared = 0;

  // shorter discharge count keeps the run brief
  ldo_mode_monitor_control #(.DISCH_CYCLES(DISCH)) i_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .i_channel_mode_select(mode), .i_low_power_standby_select(lp), .i_in_sequence(in_seq),
    .i_standby_enable_default(stby_def), .i_run_code_default(run_def), .i_stby_code_default(stby_code),
    .i_monitor_blanking_select(blank_sel), .i_monitor_mask_select(mask_sel), .i_load_defaults(load_def),
    .i_state_run(st_run), .i_state_standby(st_stby), .i_slot_now(slot_now), .i_slot_tick(slot_tick),
    .i_in_regulation(in_reg), .i_ov_raw(ov_raw), .i_uv_raw(uv_raw), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_regulator_on(reg_on), .o_channel_voltage_monitor_en(mon_en),
    .o_monitor_level(mon_lvl), .o_discharge_on(disch), .o_output_tristate(tri_st), .o_ov_fault(ov_f),
    .o_uv_fault(uv_f), .o_irq(irq));
  ext_reg_model i_ext (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_en(ext_en), .i_slow(ext_slow),
    .i_ov_cmd(ov_cmd), .i_uv_cmd(uv_cmd), .o_in_regulation(in_reg), .o_ov_raw(ov_raw), .o_uv_raw(uv_raw));

  // clock at 20 MHz
  always #25 I_CLK = ~I_CLK;

  // ****************************************************************
  // bus and timing helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge I_CLK);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge I_CLK);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge I_CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge I_CLK);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic set_state(input logic r, input logic s);
    @(posedge I_CLK);
    st_run <= r;
    st_stby <= s;
  endtask
  task automatic slots(input logic [7:0] last);
    for (int s = 1; s <= last; s++) begin
      @(posedge I_CLK);
      slot_now <= s[7:0];
      slot_tick <= 1'b1;
      @(posedge I_CLK);
      slot_tick <= 1'b0;
    end
    tick(3);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    @(posedge I_CLK);
    load_def <= 1'b1;
    @(posedge I_CLK);
    load_def <= 1'b0;
    bus_rd(ADDR_CTRL, d);
    `CHK("ctrl", 8'h03, d)
    bus_rd(ADDR_VOLT, d);
    `CHK("volt", 8'h10, d)
    bus_rd(4'hA, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  // every mode code: only regulator and switch modes drive the output
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      set_state(1'b0, 1'b0);
      mode <= m[1:0];
      tick(4);
      set_state(1'b1, 1'b0);
      tick(6);
      `CHK("regulator on", (m == 0 || m == 2), reg_on)
      bus_rd(ADDR_STAT, d);
      `CHK("mode bits", {m == 0, m == 2}, d[7:6])
    end
  endtask
  task automatic t_standby();
    set_state(1'b0, 1'b0);
    mode <= MODE_SWITCH;
    tick(4);
    set_state(1'b1, 1'b0);
    tick(6);
    `CHK("run level", run_def, mon_lvl)
    bus_wr(ADDR_SLOT, 8'h03);
    set_state(1'b0, 1'b1);
    tick(3);
    `CHK("discharge", 1'b1, disch)
    tick(DISCH + 5);
    `CHK("discharge end", 1'b0, disch)
    slots(8'h02);
    `CHK("before slot", 1'b0, reg_on)
    slots(8'h03);
    `CHK("at slot", 1'b1, reg_on)
    `CHK("standby level", stby_code, mon_lvl)
  endtask
  task automatic t_lowpower();
    set_state(1'b1, 1'b0);
    tick(6);
    set_state(1'b0, 1'b1);
    lp <= 1'b1;
    tick(3);
    `CHK("tristate", 1'b1, tri_st)
    `CHK("monitor off", 1'b0, mon_en)
    `CHK("no discharge", 1'b0, disch)
    set_state(1'b1, 1'b0);
    lp <= 1'b0;
    bus_wr(ADDR_CTRL, 8'h01);
    set_state(1'b0, 1'b1);
    tick(DISCH + 5);
    slots(8'h03);
    `CHK("standby disabled", 1'b0, reg_on)
  endtask
  // bypass turn-on with a slow external supply: full blanking, then faults and status
  task automatic t_bypass();
    set_state(1'b0, 1'b0);
    mode <= MODE_BYPASS;
    bus_wr(ADDR_CTRL, 8'h03);
    ext_en <= 1'b1;
    ext_slow <= 1'b1;
    ov_cmd <= 1'b1;
    set_state(1'b1, 1'b0);
    tick(100);
    `CHK("bypass drive", 1'b0, reg_on)
    `CHK("bypass monitor", 1'b1, mon_en)
    `CHK("blanked", 1'b0, ov_f)
    bus_rd(ADDR_STAT, d);
    `CHK("blank busy", 1'b1, d[5])
    tick(BLANK_US_0 * CLK_MHZ);
    `CHK("after blank", 1'b1, ov_f)
    `CHK("irq", 1'b1, irq)
    @(posedge I_CLK);
    ov_cmd <= 1'b0;
    tick(2);
    bus_rd(ADDR_IRQ, d);
    `CHK("status", 8'h05, d & 8'h05)
    `CHK("irq cleared", 1'b0, irq)
    bus_wr(ADDR_MASK, 8'h0F);
    ov_cmd <= 1'b1;
    tick(3);
    `CHK("irq masked", 1'b0, irq)
    bus_wr(ADDR_MASK, 8'h00);
  endtask
  task automatic t_early_and_mask();
    set_state(1'b0, 1'b0);
    ext_en <= 1'b0;
    tick(4);
    set_state(1'b1, 1'b0);
    ext_slow <= 1'b0;
    ext_en <= 1'b1;
    tick(30);
    `CHK("early monitor", 1'b1, ov_f)
    bus_wr(ADDR_VOLT, 8'h10);
    tick(3);
    `CHK("same setpoint", 1'b1, ov_f)
    bus_wr(ADDR_VOLT, 8'h12);
    tick(100);
    `CHK("masked", 1'b0, ov_f)
    bus_rd(ADDR_STAT, d);
    `CHK("mask busy", 1'b1, d[4])
    tick(MASK_US_0 * CLK_MHZ);
    `CHK("mask over", 1'b1, ov_f)
    @(posedge I_CLK);
    uv_cmd <= 1'b1;
    tick(2);
    `CHK("uv fault", 1'b1, uv_f)
  endtask
  // a longer blanking code still holds faults past the shortest blanking time
  task automatic t_blank_sel();
    set_state(1'b0, 1'b0);
    ext_en <= 1'b0;
    blank_sel <= 2'h1;
    tick(4);
    set_state(1'b1, 1'b0);
    ext_slow <= 1'b1;
    ext_en <= 1'b1;
    tick(BLANK_US_0 * CLK_MHZ + 100);
    `CHK("long blank uv", 1'b0, uv_f)
    bus_rd(ADDR_STAT, d);
    `CHK("long blank busy", 1'b1, d[5])
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    {mode, blank_sel, mask_sel} = '0;
    {lp, load_def, st_run, st_stby, slot_tick, wr, rd, ext_en, ext_slow, ov_cmd, uv_cmd} = '0;
    in_seq = 1'b1;
    stby_def = 1'b1;
    run_def = 5'h10;
    stby_code = 5'h08;
    slot_now = 8'h00;
    wdata = 8'h00;
    addr = 4'h0;
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    t_defaults();
    t_modes();
    t_standby();
    t_lowpower();
    t_bypass();
    t_early_and_mask();
    t_blank_sel();
    test_done();
  end
  // the sequence needs about 20600 cycles
  initial begin
    repeat (40000) @(posedge I_CLK);
    err_total++;
    test_done();
  end
endmodule
